// File: pss_pkg.sv
// Package for the PHY status summary register block.
// Assumes a 100 MHz ref_clk and a 5-bit management register address space.
package pss_pkg;

    // Register addresses (management address space)
    localparam logic [4:0] PSS_ADDR_BASIC_STATUS  = 5'h01;
    localparam logic [4:0] PSS_ADDR_AN_EXPANSION  = 5'h06;
    localparam logic [4:0] PSS_ADDR_SUMMARY       = 5'h10;
    localparam logic [4:0] PSS_ADDR_INT_EVENT     = 5'h12;
    localparam logic [4:0] PSS_ADDR_TENBASE_STAT  = 5'h1a;
    localparam logic [4:0] PSS_ADDR_FALSE_CARRIER = 5'h14;
    localparam logic [4:0] PSS_ADDR_RX_ERROR_CNT  = 5'h15;
    localparam logic [4:0] PSS_ADDR_IRQ_STATUS    = 5'h1c;
    localparam logic [4:0] PSS_ADDR_IRQ_MASK      = 5'h1d;

    // Field positions of the summary register
    localparam int PSS_BIT_RESERVED   = 15;
    localparam int PSS_BIT_CROSSOVER  = 14;
    localparam int PSS_BIT_RX_ERROR   = 13;
    localparam int PSS_BIT_POLARITY   = 12;
    localparam int PSS_BIT_FALSE_CARR = 11;
    localparam int PSS_BIT_SIG_DETECT = 10;
    localparam int PSS_BIT_DESCR_LOCK = 9;
    localparam int PSS_BIT_PAGE_RX    = 8;
    localparam int PSS_BIT_INT_PEND   = 7;
    localparam int PSS_BIT_REM_FAULT  = 6;

    // Interrupt status/mask layout
    localparam int PSS_IRQ_RX_ERROR   = 0;
    localparam int PSS_IRQ_FALSE_CARR = 1;
    localparam int PSS_IRQ_REM_FAULT  = 2;
    localparam int PSS_IRQ_PAGE_RX    = 3;
    localparam int PSS_IRQ_WIDTH      = 4;

    // Reset values
    localparam logic [15:0] PSS_SUMMARY_RESET = 16'h0000;
    localparam logic [3:0]  PSS_IRQ_RESET     = 4'h0;

endpackage : pss_pkg

// File: pss_summary.sv
// PHY status summary register, bits 15 down to 6, with a small interrupt unit.
// The read port answers one cycle after the strobe and never stalls the master.
// Assumes all status sources are on ref_clk except the two PMD indications,
// which come from the analog side and are synchronised here.
// Assumes the counter, mirror and basic status registers live in other units;
// only their read strobes are decoded here, to clear the matching flags.
//
// Functional notes
// - Bit 15 is reserved: writes ignored, always reads zero.
// - Bit 14 shows crossover state: one swapped pairs, zero normal pairs.
// - Crossover bit follows enable/force settings; tracks detection when auto, unforced.
// - Receive-error latch sets on any error, clears on receive error counter read.
// - Polarity bit mirrors ten-base status bit 4; cleared only by that register read or reset.
// - False-carrier latch sets on any event, clears on false carrier counter read.
// - Bit 10 is 100 Mb/s signal detect, latch-low, reset zero.
// - Bit 9 is 100 Mb/s descrambler lock, latch-low, reset zero.
// - Page-received mirrors expansion bit 1; cleared by expansion read, not summary.
// - Bit 7 is set while an interrupt is pending; event register read clears.
// - Remote-fault set by partner fault, cleared by basic status read or reset.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns

module pss_summary
    import pss_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata_q,
    // Crossover control and detection
    input  wire logic        auto_crossover_enable,
    input  wire logic        crossover_force,
    input  wire logic        crossover_detect_swapped,
    // Status events and levels from other units
    input  wire logic        rx_error_event,
    input  wire logic        false_carrier_event,
    input  wire logic        polarity_inverted_event,
    input  wire logic        page_received_event,
    input  wire logic        internal_int_pending,
    input  wire logic        remote_fault_event,
    // PMD indications, asynchronous
    input  wire logic        pmd_signal_detect,
    input  wire logic        pmd_descrambler_lock,
    // Interrupt output
    output logic             irq_q
);
    import pss_pkg::*;

    // Decodes a read strobe at one address
    function automatic logic rd_at(input logic [4:0] a, input logic [4:0] target,
                                   input logic rd);
        rd_at = rd && (a == target);
    endfunction : rd_at

    // Decodes a write strobe at one address
    function automatic logic wr_at(input logic [4:0] a, input logic [4:0] target,
                                   input logic wr);
        wr_at = wr && (a == target);
    endfunction : wr_at

    // Visible level of a latch-low bit: live source unless a drop is still held
    function automatic logic low_latched(input logic live, input logic low_seen);
        low_latched = live && !low_seen;
    endfunction : low_latched

    // Read decodes; each one clears the flags that mirror its register
    logic rd_summary;
    logic rd_basic;
    logic rd_expansion;
    logic rd_int_event;
    logic rd_tenbase;
    logic rd_false_carr;
    logic rd_rx_err_cnt;

    assign rd_summary    = rd_at(reg_addr, PSS_ADDR_SUMMARY, reg_read);
    assign rd_basic      = rd_at(reg_addr, PSS_ADDR_BASIC_STATUS, reg_read);
    assign rd_expansion  = rd_at(reg_addr, PSS_ADDR_AN_EXPANSION, reg_read);
    assign rd_int_event  = rd_at(reg_addr, PSS_ADDR_INT_EVENT, reg_read);
    assign rd_tenbase    = rd_at(reg_addr, PSS_ADDR_TENBASE_STAT, reg_read);
    assign rd_false_carr = rd_at(reg_addr, PSS_ADDR_FALSE_CARRIER, reg_read);
    assign rd_rx_err_cnt = rd_at(reg_addr, PSS_ADDR_RX_ERROR_CNT, reg_read);

    // Write decodes; the summary itself has none, so writes to it vanish
    logic wr_irq_stat;
    logic wr_irq_mask;
    assign wr_irq_stat = wr_at(reg_addr, PSS_ADDR_IRQ_STATUS, reg_write);
    assign wr_irq_mask = wr_at(reg_addr, PSS_ADDR_IRQ_MASK, reg_write);

    // Two-stage synchronisers for the PMD indications
    // Only the second stage is read, so a metastable first stage never spreads
    logic sd_meta_q;
    logic sd_sync_q;
    logic lock_meta_q;
    logic lock_sync_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sd_meta_q   <= 1'b0;
            sd_sync_q   <= 1'b0;
            lock_meta_q <= 1'b0;
            lock_sync_q <= 1'b0;
        end else begin
            sd_meta_q   <= pmd_signal_detect;
            sd_sync_q   <= sd_meta_q;
            lock_meta_q <= pmd_descrambler_lock;
            lock_sync_q <= lock_meta_q;
        end
    end

    // Crossover state: forced swap, auto detection, or normal pairs
    // Registered, so the bit lags the settings by one cycle
    logic crossover_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            crossover_q <= 1'b0;
        end else if (crossover_force) begin
            crossover_q <= 1'b1;
        end else if (auto_crossover_enable) begin
            crossover_q <= crossover_detect_swapped;
        end else begin
            crossover_q <= 1'b0;
        end
    end

    // Latch-high flags; a new event wins over a clearing read
    // A read that meets a new event in one cycle must not lose that event
    logic rx_err_q;
    logic false_carr_q;
    logic polarity_q;
    logic page_rx_q;
    logic rem_fault_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_err_q <= 1'b0;
        end else if (rx_error_event) begin
            rx_err_q <= 1'b1;
        end else if (rd_rx_err_cnt) begin
            rx_err_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            false_carr_q <= 1'b0;
        end else if (false_carrier_event) begin
            false_carr_q <= 1'b1;
        end else if (rd_false_carr) begin
            false_carr_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            polarity_q <= 1'b0;
        end else if (polarity_inverted_event) begin
            polarity_q <= 1'b1;
        end else if (rd_tenbase) begin
            polarity_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            page_rx_q <= 1'b0;
        end else if (page_received_event) begin
            page_rx_q <= 1'b1;
        end else if (rd_expansion) begin
            page_rx_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rem_fault_q <= 1'b0;
        end else if (remote_fault_event) begin
            rem_fault_q <= 1'b1;
        end else if (rd_basic) begin
            rem_fault_q <= 1'b0;
        end
    end

    // Interrupt pending: set by source, cleared by event register read
    // A source still pending at the clearing read sets the bit again
    logic int_pend_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            int_pend_q <= 1'b0;
        end else if (internal_int_pending) begin
            int_pend_q <= 1'b1;
        end else if (rd_int_event) begin
            int_pend_q <= 1'b0;
        end
    end

    // Latch-low PMD bits: a drop holds zero until a summary read
    // Cleared only while the source is high, so a read during a drop keeps zero
    logic sd_low_seen_q;
    logic lock_low_seen_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sd_low_seen_q <= 1'b0;
        end else if (!sd_sync_q) begin
            sd_low_seen_q <= 1'b1;
        end else if (rd_summary) begin
            sd_low_seen_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lock_low_seen_q <= 1'b0;
        end else if (!lock_sync_q) begin
            lock_low_seen_q <= 1'b1;
        end else if (rd_summary) begin
            lock_low_seen_q <= 1'b0;
        end
    end

    // Summary word; low six bits belong to other units and read zero here
    // Bit 15 is forced low here, whatever a write carried
    logic [15:0] summary;
    always_comb begin
        summary                     = PSS_SUMMARY_RESET;
        summary[PSS_BIT_RESERVED]   = 1'b0;
        summary[PSS_BIT_CROSSOVER]  = crossover_q;
        summary[PSS_BIT_RX_ERROR]   = rx_err_q;
        summary[PSS_BIT_POLARITY]   = polarity_q;
        summary[PSS_BIT_FALSE_CARR] = false_carr_q;
        summary[PSS_BIT_SIG_DETECT] = low_latched(sd_sync_q, sd_low_seen_q);
        summary[PSS_BIT_DESCR_LOCK] = low_latched(lock_sync_q, lock_low_seen_q);
        summary[PSS_BIT_PAGE_RX]    = page_rx_q;
        summary[PSS_BIT_INT_PEND]   = int_pend_q;
        summary[PSS_BIT_REM_FAULT]  = rem_fault_q;
    end

    // Interrupt status (write one to clear) and mask
    logic [PSS_IRQ_WIDTH-1:0] irq_stat_q;
    logic [PSS_IRQ_WIDTH-1:0] irq_mask_q;
    logic [PSS_IRQ_WIDTH-1:0] irq_stat_d;
    logic [PSS_IRQ_WIDTH-1:0] irq_mask_d;
    logic [PSS_IRQ_WIDTH-1:0] irq_events;
    logic [PSS_IRQ_WIDTH-1:0] irq_clear;
    always_comb begin
        irq_events                     = '0;
        irq_events[PSS_IRQ_RX_ERROR]   = rx_error_event;
        irq_events[PSS_IRQ_FALSE_CARR] = false_carrier_event;
        irq_events[PSS_IRQ_REM_FAULT]  = remote_fault_event;
        irq_events[PSS_IRQ_PAGE_RX]    = page_received_event;
        irq_clear  = wr_irq_stat ? reg_wdata[PSS_IRQ_WIDTH-1:0] : '0;
        irq_stat_d = (irq_stat_q & ~irq_clear) | irq_events;        // Set wins
        irq_mask_d = wr_irq_mask ? reg_wdata[PSS_IRQ_WIDTH-1:0] : irq_mask_q;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= PSS_IRQ_RESET;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_mask_q <= PSS_IRQ_RESET;
        end else begin
            irq_mask_q <= irq_mask_d;
        end
    end

    // Interrupt level output
    // Computed from next values so the level never lags the status or mask
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_d & irq_mask_d);
        end
    end

    // Read data, one cycle after the strobe, zero otherwise
    // Zero between answers, so a stale word is never taken for an answer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_q <= 16'h0000;
        end else if (reg_read) begin
            case (reg_addr)
                PSS_ADDR_SUMMARY:    reg_rdata_q <= summary;
                PSS_ADDR_IRQ_STATUS: reg_rdata_q <= {12'h000, irq_stat_q};
                PSS_ADDR_IRQ_MASK:   reg_rdata_q <= {12'h000, irq_mask_q};
                PSS_ADDR_RX_ERROR_CNT, PSS_ADDR_FALSE_CARRIER, PSS_ADDR_TENBASE_STAT,
                PSS_ADDR_AN_EXPANSION, PSS_ADDR_INT_EVENT, PSS_ADDR_BASIC_STATUS:
                                     reg_rdata_q <= 16'h0000;  // Clear-only strobes
                default:             reg_rdata_q <= 16'h0000;
            endcase
        end else begin
            reg_rdata_q <= 16'h0000;
        end
    end

endmodule : pss_summary

// File: pss_summary_props.sv
// Checker for the PHY status summary register block.
// Assumes only the top module's ports; attached by the bind at the foot.
`timescale 1ns/1ns

module pss_summary_props
    import pss_pkg::*;
(
    // Clock, reset and register port
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [4:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [15:0] reg_rdata_q,
    // Status sources and interrupt
    input wire logic        auto_crossover_enable,
    input wire logic        crossover_force,
    input wire logic        rx_error_event,
    input wire logic        false_carrier_event,
    input wire logic        page_received_event,
    input wire logic        remote_fault_event,
    input wire logic        irq_q
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Summary reads and anything that may raise the interrupt
    wire sum_rd = reg_read && (reg_addr == PSS_ADDR_SUMMARY);
    wire cause  = rx_error_event || false_carrier_event || page_received_event
                  || remote_fault_event || (reg_write && reg_addr == PSS_ADDR_IRQ_MASK);

    a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata_q == 16'h0000)
        else $error("read data not zero outside read answer");
    a_reserved_bit_zero: assert property (sum_rd |=> !reg_rdata_q[15])
        else $error("reserved bit read as one");
    a_cross_forced: assert property (
        sum_rd && crossover_force && $past(crossover_force) |=> reg_rdata_q[14])
        else $error("forced crossover not reported");
    a_cross_off: assert property (
        sum_rd && !crossover_force && !auto_crossover_enable
        && $past(!crossover_force && !auto_crossover_enable) |=> !reg_rdata_q[14])
        else $error("crossover reported while disabled");
    a_rxerr_latched: assert property (rx_error_event ##1 sum_rd |=> reg_rdata_q[13])
        else $error("receive error latch not set");
    a_fcarr_latched: assert property (false_carrier_event ##1 sum_rd |=> reg_rdata_q[11])
        else $error("false carrier latch not set");
    a_page_latched: assert property (page_received_event ##1 sum_rd |=> reg_rdata_q[8])
        else $error("page received flag not set");
    a_rfault_latched: assert property (remote_fault_event ##1 sum_rd |=> reg_rdata_q[6])
        else $error("remote fault flag not set");
    a_irq_has_cause: assert property ($rose(irq_q) |-> $past(cause) || $past(cause, 2))
        else $error("interrupt rose without a cause");
    a_w1c_drops_irq: assert property (reg_write && reg_addr == PSS_ADDR_IRQ_STATUS
        && reg_wdata[3:0] == 4'hf && !cause |=> !irq_q)
        else $error("interrupt stayed high after clearing all status");
endmodule : pss_summary_props

bind pss_summary pss_summary_props u_props (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata_q, .auto_crossover_enable, .crossover_force, .rx_error_event,
    .false_carrier_event, .page_received_event, .remote_fault_event, .irq_q);

// File: tb_top.sv
// Self-checking bench for the PHY status summary register block.
// Assumes pss_pkg and pss_summary are compiled first; drives every port itself.
`timescale 1ns/1ns

module tb_top;
    import pss_pkg::*;
    logic        ref_clk, rst, reg_write, reg_read, irq_q;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata_q, got;
    logic [2:0]  xs;
    logic [5:0]  ev, e6;
    logic [1:0]  pmd;
    logic [3:0]  m4;
    int          n_errors, comparisons, seed, i, k;
    int          pos [6] = '{PSS_BIT_RX_ERROR, PSS_BIT_FALSE_CARR, PSS_BIT_POLARITY,
                             PSS_BIT_PAGE_RX, PSS_BIT_INT_PEND, PSS_BIT_REM_FAULT};
    logic [4:0]  clr [6] = '{PSS_ADDR_RX_ERROR_CNT, PSS_ADDR_FALSE_CARRIER,
                             PSS_ADDR_TENBASE_STAT, PSS_ADDR_AN_EXPANSION,
                             PSS_ADDR_INT_EVENT, PSS_ADDR_BASIC_STATUS};

    // Device under test; xs is auto, force, detect and ev the six event sources
    pss_summary uut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata_q, .auto_crossover_enable(xs[2]), .crossover_force(xs[1]),
        .crossover_detect_swapped(xs[0]), .rx_error_event(ev[0]),
        .false_carrier_event(ev[1]), .polarity_inverted_event(ev[2]),
        .page_received_event(ev[3]), .internal_int_pending(ev[4]),
        .remote_fault_event(ev[5]), .pmd_signal_detect(pmd[1]),
        .pmd_descrambler_lock(pmd[0]), .irq_q);

    // Expected summary bits for a set of events
    function automatic logic [15:0] exp_sum(input logic [5:0] e);
        logic [15:0] s;
        s = 16'h0000;
        for (int j = 0; j < 6; j++) begin
            s[pos[j]] = e[j];
        end
        return s;
    endfunction : exp_sum

    // Expected interrupt status: rx error, false carrier, remote fault, page
    function automatic logic [3:0] exp_irq(input logic [5:0] e);
        return {e[3], e[5], e[1], e[0]};
    endfunction : exp_irq

    task automatic final_report;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One-cycle write strobe
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask : wr

    // One-cycle read strobe; data taken in the answer cycle only
    task automatic rd(input logic [4:0] a);
        @(posedge ref_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 got = reg_rdata_q;
    endtask : rd

    task automatic pulse(input logic [5:0] e);
        @(posedge ref_clk);
        ev <= e;
        @(posedge ref_clk);
        ev <= 6'h00;
    endtask : pulse

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        final_report();
    end

    // Main sequence
    initial begin
        {rst, reg_write, reg_read, reg_addr, reg_wdata} = {1'b1, 23'h0};
        {xs, ev, pmd, n_errors, comparisons, seed} = {11'h0, 32'd0, 32'd0, 32'd54};
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        rd(PSS_ADDR_SUMMARY);
        chk("reset value", PSS_SUMMARY_RESET, got);
        wr(PSS_ADDR_SUMMARY, 16'hffff);
        rd(PSS_ADDR_SUMMARY);
        chk("write ignored", 16'h0000, got);
        rd(5'h1f);
        chk("unmapped read", 16'h0000, got);
        // Corner: all events, then a summary read in the very next cycle
        @(posedge ref_clk);
        ev <= 6'h3f;
        @(posedge ref_clk);
        ev       <= 6'h00;
        reg_read <= 1'b1;
        reg_addr <= PSS_ADDR_SUMMARY;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 got = reg_rdata_q;
        chk("next cycle", exp_sum(6'h3f), got);
        for (k = 0; k < 6; k++) begin
            rd(clr[k]);
        end
        wr(PSS_ADDR_IRQ_STATUS, 16'h000f);
        // Every crossover setting
        for (k = 0; k < 8; k++) begin
            @(posedge ref_clk);
            xs <= k[2:0];
            rd(PSS_ADDR_SUMMARY);
            rd(PSS_ADDR_SUMMARY);
            chk("crossover", {1'b0, k[1] | (k[2] & k[0]), 14'h0}, got);
        end
        xs <= 3'b000;
        // Random events and masks, all events first and a zero mask second
        for (i = 0; i < 8; i++) begin
            e6 = (i == 0) ? 6'h3f : 6'($random(seed));
            m4 = (i == 1) ? 4'h0 : 4'($random(seed));
            wr(PSS_ADDR_IRQ_MASK, {12'h0, m4});
            pulse(e6);
            repeat (2) @(posedge ref_clk);
            #1 chk("irq level", {15'h0, |(exp_irq(e6) & m4)}, {15'h0, irq_q});
            rd(PSS_ADDR_IRQ_STATUS);
            chk("irq status", {12'h0, exp_irq(e6)}, got);
            rd(PSS_ADDR_SUMMARY);
            rd(PSS_ADDR_SUMMARY);
            chk("latched flags", exp_sum(e6), got);
            for (k = 0; k < 6; k++) begin
                rd(clr[k]);
            end
            rd(PSS_ADDR_SUMMARY);
            chk("cleared flags", 16'h0000, got);
            wr(PSS_ADDR_IRQ_STATUS, 16'h000f);
            #1 chk("irq cleared", 16'h0000, {15'h0, irq_q});
        end
        // Latch-low: low seen at reset, then a short dip
        @(posedge ref_clk);
        for (k = 0; k < 2; k++) begin
            pmd <= 2'b11;
            repeat (4) @(posedge ref_clk);
            rd(PSS_ADDR_SUMMARY);
            chk("low held", 16'h0000, got);
            rd(PSS_ADDR_SUMMARY);
            chk("pmd high", 16'h0600, got);
            pmd <= 2'b00;
            repeat (2) @(posedge ref_clk);
        end
        final_report();
    end
endmodule : tb_top
